// *** src/icc_map.svh ***
// Register offsets, field positions and reset values of the internal clock control block
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

`define ICC_SELSTAT_OFFSET 4'h0
`define ICC_HIBASE_OFFSET 4'h4
`define ICC_DIVSTAT_OFFSET 4'h8
`define ICC_FSEL_MSB 5
`define ICC_FSEL_LSB 4
`define ICC_LOCKED_BIT 3
`define ICC_STABLE_BIT 2
`define ICC_FSEL_RESET 2'h2
`define ICC_HIBASE_RESET 1'h1
`define ICC_DIV_W 5
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2

`endif

// *** src/icc_pkg.sv ***
// Types shared by the internal clock control block
`default_nettype none

package icc_pkg;
	// Postscale codes: divide the base oscillator by 8, 4, 2 or 1
	typedef enum logic [1:0] {
		ICC_DIV8 = 2'h0,
		ICC_DIV4 = 2'h1,
		ICC_DIV2 = 2'h2,
		ICC_DIV1 = 2'h3
	} icc_fsel_e;
	typedef logic [31:0] icc_word_t;
endpackage : icc_pkg

`default_nettype wire

// *** src/icc_postscaler.sv ***
// Glitch-free postscaler that turns a base oscillator enable stream into the system clock enable
`default_nettype none
`include "icc_map.svh"

module icc_postscaler (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic [1:0] freq_select,
	input wire logic base_tick,
	// Result
	output logic sys_tick,
	output logic [1:0] active_select
);
	import icc_pkg::*;

	logic [`ICC_DIV_W-1:0] cnt_q, cnt_d;
	logic [1:0] act_q, act_d;
	logic [`ICC_DIV_W-1:0] limit;
	logic wrap;
	logic tick_q, tick_d;

	// Terminal count of the active divider
	always_comb begin
		case (act_q)
			2'h0: limit = `ICC_DIV_W'(7);
			2'h1: limit = `ICC_DIV_W'(3);
			2'h2: limit = `ICC_DIV_W'(1);
			default: limit = `ICC_DIV_W'(0);
		endcase
	end

	assign wrap = base_tick && (cnt_q >= limit);

	// New ratio only taken at the end of a whole output period, so no short pulse escapes
	always_comb begin
		cnt_d = cnt_q;
		act_d = act_q;
		tick_d = 1'b0;
		if (wrap) begin
			cnt_d = '0;
			act_d = freq_select;
			tick_d = 1'b1;
		end else if (base_tick) begin
			cnt_d = cnt_q + `ICC_DIV_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			act_q <= `ICC_FSEL_RESET;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			act_q <= act_d;
			tick_q <= tick_d;
		end
	end

	assign sys_tick = tick_q;
	assign active_select = act_q;
endmodule : icc_postscaler

`default_nettype wire

// *** src/icc_top.sv ***
// Internal oscillator frequency select and status register block with an AXI4-Lite slave
//
// Notes on behaviour
// - With the high base chosen, select codes 11/10/01/00 give 16, 8, 4 and 2 MHz.
// - With the low base chosen, select codes 11/10/01/00 give 500, 250, 125 and 62.5 kHz.
// - Reset loads select code 10, so 8 MHz or 250 kHz.
// - Bit 3 reads 1 once the base oscillator is within 2%, else 0, and ignores writes.
// - Bit 2 reads 1 once the base oscillator is within 0.5%, else 0, and ignores writes.
// - Bits 7, 6, 1 and 0 of the select/status register ignore writes and read zero.
//
// The address map and register access over AXI4-Lite were decided locally.
`default_nettype none
`include "icc_map.svh"

module icc_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output icc_pkg::icc_word_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Oscillator side
	input wire logic base_tick,
	input wire logic osc_within_2pct,
	input wire logic osc_within_half_pct,
	// Clock control outputs
	output logic high_base_enable,
	output logic [1:0] freq_select,
	output logic sys_tick
);
	import icc_pkg::*;

	//----------------------------------------
	// Status synchronisers
	//----------------------------------------
	logic [1:0] lock_sync_q, lock_sync_d;
	logic [1:0] stab_sync_q, stab_sync_d;
	logic osc_locked_flag, osc_stable_flag;

	// Oscillator status comes from the analog trim loop, so two flops first
	always_comb begin
		lock_sync_d = {lock_sync_q[0], osc_within_2pct};
		stab_sync_d = {stab_sync_q[0], osc_within_half_pct};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_sync_q <= 2'h0;
			stab_sync_q <= 2'h0;
		end else begin
			lock_sync_q <= lock_sync_d;
			stab_sync_q <= stab_sync_d;
		end
	end

	assign osc_locked_flag = lock_sync_q[1];
	assign osc_stable_flag = stab_sync_q[1];

	//----------------------------------------
	// Write channel
	//----------------------------------------
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [3:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic [1:0] fsel_q, fsel_d;
	logic hibase_q, hibase_d;
	logic wr_fire;

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

	// Address and data are caught separately in either order; the commit waits for both
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		fsel_d = fsel_q;
		hibase_d = hibase_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `ICC_RESP_OKAY;
			case ({aw_addr_q[3:2], 2'h0})
				`ICC_SELSTAT_OFFSET: begin
					// Only the select field is stored; status and unused bits drop the write
					if (w_strb_q[0]) begin
						fsel_d = w_data_q[`ICC_FSEL_MSB:`ICC_FSEL_LSB];
					end
				end
				`ICC_HIBASE_OFFSET: begin
					if (w_strb_q[0]) begin
						hibase_d = w_data_q[0];
					end
				end
				`ICC_DIVSTAT_OFFSET: begin
					bresp_d = `ICC_RESP_OKAY; // Read-only, write ignored
				end
				default: begin
					bresp_d = `ICC_RESP_SLVERR;
				end
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `ICC_RESP_OKAY;
			fsel_q <= `ICC_FSEL_RESET;
			hibase_q <= `ICC_HIBASE_RESET;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			fsel_q <= fsel_d;
			hibase_q <= hibase_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	//----------------------------------------
	// Postscaler
	//----------------------------------------
	logic [1:0] active_select;

	// Same divide ratios serve both bases: 16 MHz/500 kHz down to 2 MHz/62.5 kHz
	icc_postscaler u_post (
		.aclk(aclk),
		.aresetn(aresetn),
		.freq_select(fsel_q),
		.base_tick(base_tick),
		.sys_tick(sys_tick),
		.active_select(active_select)
	);

	assign high_base_enable = hibase_q;
	assign freq_select = fsel_q;

	//----------------------------------------
	// Read channel
	//----------------------------------------
	logic rvalid_q, rvalid_d;
	icc_word_t rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	assign s_axi_arready = !rvalid_q;

	// One read in flight; data registered so it stays put while rvalid waits
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d = 32'h0; // Unused bits read zero
			rresp_d = `ICC_RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'h0})
				`ICC_SELSTAT_OFFSET: begin
					rdata_d[`ICC_FSEL_MSB:`ICC_FSEL_LSB] = fsel_q;
					rdata_d[`ICC_LOCKED_BIT] = osc_locked_flag;
					rdata_d[`ICC_STABLE_BIT] = osc_stable_flag;
				end
				`ICC_HIBASE_OFFSET: begin
					rdata_d[0] = hibase_q;
				end
				`ICC_DIVSTAT_OFFSET: begin
					rdata_d[1:0] = active_select;
				end
				default: begin
					rresp_d = `ICC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `ICC_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule : icc_top

`default_nettype wire

// *** verification/icc_chk_sva.sv ***
// Concurrent checks on the ports of the internal clock control block
`default_nettype none

module icc_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire icc_pkg::icc_word_t s_axi_rdata,
	input wire logic s_axi_bvalid,
	// Clock control
	input wire logic base_tick,
	input wire logic osc_within_2pct,
	input wire logic osc_within_half_pct,
	input wire logic high_base_enable,
	input wire logic [1:0] freq_select,
	input wire logic sys_tick
);
	import icc_pkg::*;
	logic [3:0] ra_q;
	// ----------------------------------------
	// Read offset, kept so read data can be judged
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ra_q <= s_axi_araddr;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Reset itself is the cause here, so this one is never disabled
	rst_load_a: assert property (disable iff (1'b0) !aresetn |=> freq_select == 2'h2 && high_base_enable)
		else $error("select field or base choice not at reset value");
	sel_fields_a: assert property ($rose(s_axi_rvalid) && ra_q == 4'h0 |->
		s_axi_rdata[31:6] == '0 && s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[5:4] == freq_select)
		else $error("select register reads wrong field values");
	// Flags pass two sync flops, then the read register
	status_a: assert property ($rose(s_axi_rvalid) && ra_q == 4'h0 |->
		s_axi_rdata[3:2] == {$past(osc_within_2pct, 3), $past(osc_within_half_pct, 3)})
		else $error("status flags do not follow the oscillator");
	base_read_a: assert property ($rose(s_axi_rvalid) && ra_q == 4'h4 |->
		s_axi_rdata == {31'h0, high_base_enable})
		else $error("base choice register reads wrong value");
	tick_cause_a: assert property (sys_tick |-> $past(base_tick))
		else $error("system tick without a base tick");
	sel_change_a: assert property ($changed(freq_select) |-> ##[0:1] s_axi_bvalid)
		else $error("select field changed without a write");
	cover property (sys_tick && freq_select == 2'h3);
	cover property (sys_tick && !high_base_enable);
	cover property ($rose(s_axi_rvalid) && ra_q == 4'h0);
endmodule : icc_chk

bind icc_top icc_chk i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_bvalid, .base_tick, .osc_within_2pct, .osc_within_half_pct, .high_base_enable,
	.freq_select, .sys_tick);

`default_nettype wire

// *** verification/icc_top_tb.sv ***
// Self-checking bench for the internal clock control block
`default_nettype none
`include "icc_map.svh"

module icc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import icc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, base_tick = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, osc_within_2pct = 1'b0, osc_within_half_pct = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, high_base_enable, sys_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp, freq_select;
	icc_word_t s_axi_rdata;
	int num_errors = 0;
	int comparisons = 0;

	icc_top i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.base_tick, .osc_within_2pct, .osc_within_half_pct, .high_base_enable, .freq_select, .sys_tick);

	// 40 MHz clock; base oscillator ticks every other cycle
	always #12.5 aclk = !aclk;
	always @(posedge aclk) begin
		base_tick <= !base_tick;
	end

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Readies are sampled mid-cycle, where they already show the next edge's values
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
	endtask : rd

	// Let the old period wrap, then count ticks over a window every period divides
	task automatic cnt(input int exp);
		int n;
		n = 0;
		repeat (40) @(posedge aclk);
		repeat (64) begin
			@(negedge aclk);
			n += sys_tick;
		end
		// Hand back on a rising edge so the next bus request starts there
		@(posedge aclk);
		chk(n, exp);
	endtask : cnt

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk(freq_select, 2'h2);
		rd(`ICC_SELSTAT_OFFSET, d, r);
		chk(d, 32'h20);
		rd(`ICC_HIBASE_OFFSET, d, r);
		chk(d, 32'h1);
		cnt(16);
	endtask : t_reset

	// Every code under both bases; all other bits written as ones
	task automatic t_sel();
		logic [31:0] d;
		logic [1:0] r;
		for (int h = 1; h >= 0; h--) begin
			wr(`ICC_HIBASE_OFFSET, 32'(h), r);
			chk(high_base_enable, 32'(h));
			for (int c = 0; c < 4; c++) begin
				wr(`ICC_SELSTAT_OFFSET, 32'hffffffcf | 32'(c << 4), r);
				chk(r, `ICC_RESP_OKAY);
				chk(freq_select, 32'(c));
				rd(`ICC_SELSTAT_OFFSET, d, r);
				chk(d, 32'(c << 4));
				cnt(4 << c);
				// The postscaler must have taken the new code by now
				rd(`ICC_DIVSTAT_OFFSET, d, r);
				chk(r, `ICC_RESP_OKAY);
				chk(d, 32'(c));
			end
		end
	endtask : t_sel

	task automatic t_status();
		logic [31:0] d;
		logic [1:0] r;
		for (int s = 0; s < 4; s++) begin
			osc_within_2pct <= s[1];
			osc_within_half_pct <= s[0];
			repeat (4) @(posedge aclk);
			wr(`ICC_SELSTAT_OFFSET, 32'h0, r);
			rd(`ICC_SELSTAT_OFFSET, d, r);
			chk(d, 32'(s << 2));
		end
	endtask : t_status

	task automatic t_unmap();
		logic [31:0] d;
		logic [1:0] r;
		wr(4'hc, 32'hffffffff, r);
		chk(r, `ICC_RESP_SLVERR);
		rd(4'hc, d, r);
		chk(r, `ICC_RESP_SLVERR);
		chk(d, 32'h0);
	endtask : t_unmap

	// Reset again in mid-run once both fields have left their reset values
	task automatic t_rerst();
		logic [31:0] d;
		logic [1:0] r;
		wr(`ICC_HIBASE_OFFSET, 32'h0, r);
		wr(`ICC_SELSTAT_OFFSET, 32'h30, r);
		chk(freq_select, 32'h3);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(freq_select, 32'h2);
		chk(high_base_enable, 32'h1);
		cnt(16);
		// Status inputs are still high, so both flags are back after the sync flops refill
		rd(`ICC_SELSTAT_OFFSET, d, r);
		chk(d, 32'h2c);
	endtask : t_rerst

	task automatic conclude();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_sel();
		t_status();
		t_unmap();
		t_rerst();
		conclude();
	end

	// Watchdog: the tests need well under 3000 cycles
	initial begin
		#200us;
		num_errors++;
		conclude();
	end
endmodule : icc_top_tb

`default_nettype wire
